// [verilog/bram_pkg.sv]
// Constants and types shared by the dual-port block RAM
// Contract
// RULE1 - 4096 bits, concurrent write and read ports
// RULE2 - Default data paths sixteen bits wide
// RULE3 - Read mode selects 256x16 to 2048x2
// RULE4 - Write mode selects 256x16 to 2048x2
// RULE5 - Contents optionally preset before normal operation
// RULE6 - Sixteen 256-bit init strings, in order
// RULE7 - Four variants choose each port's active edge
// RULE8 - Active-low bit mask only in mode 0
// RULE9 - User drives write address and data
// RULE10 - Write only while write enable high
// RULE11 - Write port captures on its active edge
// RULE12 - Write clock gate low ignores edges
// RULE13 - User drives read address, gets data
// RULE14 - Read only while read strobe high
// RULE15 - Read port samples on its active edge
// RULE16 - Read clock gate low holds output
// RULE17 - Read data registered after active edge
// RULE18 - Same-address collision result is undefined
package bram_pkg;

    // ----------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------
    localparam int TOTAL_BITS   = 4096;
    localparam int WORD_W       = 16;
    localparam int DEPTH        = 256;
    localparam int PORT_ADDR_W  = 11;
    localparam int INIT_STRINGS = 16;
    localparam int INIT_W       = 256;
    localparam int WORDS_PER_IN = INIT_W / WORD_W;

    // ----------------------------------------------------------
    // Edge variants
    // ----------------------------------------------------------
    typedef enum {
        block_ram_rise_rise,
        block_ram_fall_read,
        block_ram_fall_write,
        block_ram_fall_both
    } variant_t;

    // ----------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------
    localparam int         AXI_ADDR_W     = 4;
    localparam logic [3:0] CTRL_OFFSET    = 4'h0;
    localparam logic [3:0] STATUS_OFFSET  = 4'h4;
    localparam logic [3:0] RELOAD_OFFSET  = 4'h8;
    localparam int         CTRL_WR_INH    = 0;
    localparam int         CTRL_RD_INH    = 1;
    localparam int         STATUS_BUSY    = 0;
    localparam int         STATUS_CNT_LSB = 16;
    localparam logic [1:0] CTRL_RESET     = 2'h0;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

endpackage : bram_pkg

// [verilog/dual_port_block_ram_4kbit.sv]
// Dual-port 4 Kbit block RAM with edge-selectable ports and register slave
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module dual_port_block_ram_4kbit
    import bram_pkg::*;
#(
    parameter int                               WRITE_MODE     = 0,
    parameter int                               READ_MODE      = 0,
    parameter variant_t                         VARIANT        = block_ram_rise_rise,
    parameter bit                               PRELOAD_ENABLE = 1'b0,
    parameter logic [INIT_STRINGS-1:0][INIT_W-1:0] INIT_IMAGE  = '0
) (
    // Clock and reset
    input  wire logic                   I_CLOCK,
    input  wire logic                   I_RST,
    // Write port
    input  wire logic                   I_WRITE_CLK,
    input  wire logic                   I_WRITE_PORT_CLOCK_GATE,
    input  wire logic                   I_WRITE_ENABLE,
    input  wire logic [PORT_ADDR_W-1:0] I_WRITE_ADDR,
    input  wire logic [WORD_W-1:0]      I_WRITE_DATA,
    input  wire logic [WORD_W-1:0]      I_WRITE_MASK_N,
    // Read port
    input  wire logic                   I_READ_CLK,
    input  wire logic                   I_READ_PORT_CLOCK_GATE,
    input  wire logic                   I_READ_STROBE,
    input  wire logic [PORT_ADDR_W-1:0] I_READ_ADDR,
    output logic      [WORD_W-1:0]      O_READ_DATA,
    // AXI4-Lite write channels
    input  wire logic [AXI_ADDR_W-1:0]  I_AWADDR,
    input  wire logic                   I_AWVALID,
    output logic                        O_AWREADY,
    input  wire logic [31:0]            I_WDATA,
    input  wire logic [3:0]             I_WSTRB,
    input  wire logic                   I_WVALID,
    output logic                        O_WREADY,
    output logic      [1:0]             O_BRESP,
    output logic                        O_BVALID,
    input  wire logic                   I_BREADY,
    // AXI4-Lite read channels
    input  wire logic [AXI_ADDR_W-1:0]  I_ARADDR,
    input  wire logic                   I_ARVALID,
    output logic                        O_ARREADY,
    output logic      [31:0]            O_RDATA,
    output logic      [1:0]             O_RRESP,
    output logic                        O_RVALID,
    input  wire logic                   I_RREADY
);

    // ----------------------------------------------------------
    // Port geometry
    // ----------------------------------------------------------
    localparam int         WW      = WORD_W >> WRITE_MODE;
    localparam int         RW      = WORD_W >> READ_MODE;
    localparam logic [2:0] WLANE_M = 3'((1 << WRITE_MODE) - 1);
    localparam logic [2:0] RLANE_M = 3'((1 << READ_MODE) - 1);
    localparam bit         W_FALL  = (VARIANT == block_ram_fall_write) ||
                                     (VARIANT == block_ram_fall_both);
    localparam bit         R_FALL  = (VARIANT == block_ram_fall_read) ||
                                     (VARIANT == block_ram_fall_both);

    logic [WORD_W-1:0] mem [DEPTH];

    logic              wclk_prev_q;
    logic              rclk_prev_q;
    logic [WORD_W-1:0] rdata_q;
    logic [7:0]        load_cnt_q;
    logic              busy_q;
    logic [1:0]        ctrl_q;
    logic [15:0]       wr_cnt_q;
    logic              awready_q;
    logic              wready_q;
    logic              aw_got_q;
    logic              w_got_q;
    logic [3:0]        awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [31:0]       axi_rdata_q;
    logic [1:0]        rresp_q;

    // ----------------------------------------------------------
    // Port edge detection
    // ----------------------------------------------------------
    wire w_edge = W_FALL ? (wclk_prev_q & ~I_WRITE_CLK)     // RULE7
                         : (~wclk_prev_q & I_WRITE_CLK);    // RULE11
    wire r_edge = R_FALL ? (rclk_prev_q & ~I_READ_CLK)      // RULE7
                         : (~rclk_prev_q & I_READ_CLK);     // RULE15

    wire user_wr = w_edge & I_WRITE_PORT_CLOCK_GATE & I_WRITE_ENABLE   // RULE10 RULE12
                 & ~ctrl_q[CTRL_WR_INH] & ~busy_q;
    wire user_rd = r_edge & I_READ_PORT_CLOCK_GATE & I_READ_STROBE     // RULE14 RULE16
                 & ~ctrl_q[CTRL_RD_INH] & ~busy_q;

    // ----------------------------------------------------------
    // Write and read lanes, write mask
    // ----------------------------------------------------------
    wire [PORT_ADDR_W-1:0] wshift = I_WRITE_ADDR >> WRITE_MODE;   // RULE4
    wire [7:0]             wword  = wshift[7:0];                  // RULE9
    wire [2:0]             wlane  = I_WRITE_ADDR[2:0] & WLANE_M;
    wire [PORT_ADDR_W-1:0] rshift = I_READ_ADDR >> READ_MODE;     // RULE3
    wire [7:0]             rword  = rshift[7:0];                  // RULE13
    wire [2:0]             rlane  = I_READ_ADDR[2:0] & RLANE_M;
    wire [WORD_W-1:0]      rstore = mem[rword];
    wire [WORD_W-1:0]      wstore = mem[wword];

    logic [WORD_W-1:0] bit_we;
    logic [WORD_W-1:0] wbits;
    logic [WORD_W-1:0] rsel;

    genvar gi;
    generate
        for (gi = 0; gi < WORD_W; gi++) begin : g_bit
            localparam logic [2:0] LANE = 3'(gi / WW);
            localparam int         IDXS = gi;
            wire [4:0] ridx = 5'(rlane * RW + IDXS);
            assign bit_we[gi] = (WRITE_MODE == 0) ? ~I_WRITE_MASK_N[gi]   // RULE8
                                                  : (wlane == LANE);
            assign wbits[gi]  = I_WRITE_DATA[gi % WW];                   // RULE2
            assign rsel[gi]   = (gi < RW) ? rstore[ridx[3:0]] : 1'b0;    // RULE3
        end
    endgenerate

    wire [WORD_W-1:0] merged = (wstore & ~bit_we) | (wbits & bit_we);    // RULE8

    // ----------------------------------------------------------
    // Preload image
    // ----------------------------------------------------------
    wire [3:0]        init_str  = load_cnt_q[7:4];                       // RULE6
    wire [3:0]        init_slot = load_cnt_q[3:0];
    wire [WORD_W-1:0] init_word = INIT_IMAGE[init_str][init_slot*WORD_W +: WORD_W];
    wire              load_last = (load_cnt_q == 8'hff);

    // ----------------------------------------------------------
    // Storage array
    // ----------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (busy_q) begin
            mem[load_cnt_q] <= init_word;                                // RULE5
        end else if (user_wr) begin
            mem[wword] <= merged;                                        // RULE1
        end
    end

    // ----------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------
    wire do_aw     = I_AWVALID & awready_q;
    wire do_w      = I_WVALID & wready_q;
    wire do_write  = aw_got_q & w_got_q & ~bvalid_q;
    wire wr_ctrl   = do_write & (awaddr_q == CTRL_OFFSET);
    wire wr_reload = do_write & (awaddr_q == RELOAD_OFFSET) & wstrb_q[0] & wdata_q[0];
    wire wr_hit    = (awaddr_q == CTRL_OFFSET) | (awaddr_q == STATUS_OFFSET) |
                     (awaddr_q == RELOAD_OFFSET);
    wire do_ar     = I_ARVALID & arready_q;
    wire rd_ctrl   = (I_ARADDR == CTRL_OFFSET);
    wire rd_status = (I_ARADDR == STATUS_OFFSET);
    wire rd_reload = (I_ARADDR == RELOAD_OFFSET);

    wire [31:0] status_word = {wr_cnt_q, 15'h0000, busy_q};
    wire [31:0] rd_word = rd_ctrl   ? {30'h00000000, ctrl_q} :
                          rd_status ? status_word : 32'h00000000;
    wire        rd_hit  = rd_ctrl | rd_status | rd_reload;

    // ----------------------------------------------------------
    // Port state
    // ----------------------------------------------------------
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            wclk_prev_q <= W_FALL;
            rclk_prev_q <= R_FALL;
            rdata_q     <= '0;
        end else begin
            wclk_prev_q <= I_WRITE_CLK;
            rclk_prev_q <= I_READ_CLK;
            if (user_rd) begin
                rdata_q <= rsel;                                         // RULE17
            end
        end
    end

    // ----------------------------------------------------------
    // Loader
    // ----------------------------------------------------------
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            busy_q     <= PRELOAD_ENABLE;                                // RULE5
            load_cnt_q <= 8'h00;
        end else if (busy_q) begin
            load_cnt_q <= load_cnt_q + 8'h01;
            busy_q     <= ~load_last;
        end else if (wr_reload) begin
            busy_q     <= 1'b1;
            load_cnt_q <= 8'h00;
        end
    end

    // ----------------------------------------------------------
    // Control and counters
    // ----------------------------------------------------------
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_q   <= CTRL_RESET;
            wr_cnt_q <= 16'h0000;
        end else begin
            if (wr_ctrl && wstrb_q[0]) begin
                ctrl_q <= wdata_q[1:0];
            end
            if (user_wr) begin
                wr_cnt_q <= wr_cnt_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awaddr_q  <= 4'h0;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            awready_q <= I_AWVALID & ~awready_q & ~aw_got_q & ~bvalid_q;
            wready_q  <= I_WVALID & ~wready_q & ~w_got_q & ~bvalid_q;
            if (do_aw) begin
                aw_got_q <= 1'b1;
                awaddr_q <= I_AWADDR;
            end
            if (do_w) begin
                w_got_q <= 1'b1;
                wdata_q <= I_WDATA;
                wstrb_q <= I_WSTRB;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && I_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            arready_q   <= 1'b0;
            rvalid_q    <= 1'b0;
            axi_rdata_q <= 32'h00000000;
            rresp_q     <= RESP_OKAY;
        end else begin
            arready_q <= I_ARVALID & ~arready_q & ~rvalid_q;
            if (do_ar) begin
                rvalid_q    <= 1'b1;
                axi_rdata_q <= rd_word;
                rresp_q     <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && I_RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------
    assign O_READ_DATA = rdata_q;
    assign O_AWREADY   = awready_q;
    assign O_WREADY    = wready_q;
    assign O_BVALID    = bvalid_q;
    assign O_BRESP     = bresp_q;
    assign O_ARREADY   = arready_q;
    assign O_RVALID    = rvalid_q;
    assign O_RDATA     = axi_rdata_q;
    assign O_RRESP     = rresp_q;

endmodule : dual_port_block_ram_4kbit

// [verif/bram_checker.sv]
// Port-level assertions for the dual-port block RAM
`timescale 1ns/1ps
module bram_checker
    import bram_pkg::*;
(
    // Clock, reset and read port
    input wire logic              I_CLOCK,
    input wire logic              I_RST,
    input wire logic              I_READ_CLK,
    input wire logic              I_READ_PORT_CLOCK_GATE,
    input wire logic              I_READ_STROBE,
    input wire logic [WORD_W-1:0] O_READ_DATA,
    // Register bus
    input wire logic              I_AWVALID,
    input wire logic              O_AWREADY,
    input wire logic              I_WVALID,
    input wire logic              O_WREADY,
    input wire logic              O_BVALID,
    input wire logic              I_ARVALID,
    input wire logic              O_ARREADY,
    input wire logic              O_RVALID,
    input wire logic [1:0]        O_RRESP,
    input wire logic [31:0]       O_RDATA
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    property p_rd_edge; (!I_READ_CLK || $past(I_READ_CLK)) |=> $stable(O_READ_DATA); endproperty
    a_rd_edge: assert property (p_rd_edge) else $error("read data moved off edge");
    property p_rd_strobe; !I_READ_STROBE |=> $stable(O_READ_DATA); endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("read data moved, strobe low");
    property p_rd_gate; !I_READ_PORT_CLOCK_GATE |=> $stable(O_READ_DATA); endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("read data moved, gate low");
    property p_aw_pulse; O_AWREADY |=> !O_AWREADY; endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than one cycle");
    property p_b_after;
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID;
    endproperty
    a_b_after: assert property (p_b_after) else $error("no write response");
    property p_ar_prompt; $rose(I_ARVALID) |-> ##[1:2] O_ARREADY; endproperty
    a_ar_prompt: assert property (p_ar_prompt) else $error("arready late");
    property p_r_after; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
    a_r_after: assert property (p_r_after) else $error("no read response");
    property p_err_zero; O_RVALID && O_RRESP == RESP_SLVERR |-> O_RDATA == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read data not zero");
endmodule : bram_checker

bind dual_port_block_ram_4kbit bram_checker i_chk (
    .I_CLOCK, .I_RST, .I_READ_CLK, .I_READ_PORT_CLOCK_GATE, .I_READ_STROBE, .O_READ_DATA,
    .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID, .I_ARVALID, .O_ARREADY,
    .O_RVALID, .O_RRESP, .O_RDATA
);

// [verif/fabric_user.sv]
// Model of the fabric logic that drives both memory ports
`timescale 1ns/1ps
module fabric_user
    import bram_pkg::*;
(
    // Clock and returned data
    input  wire logic                   i_clock,
    input  wire logic [WORD_W-1:0]      i_rdata,
    // Write port
    output logic                        o_wclk,
    output logic                        o_wgate,
    output logic                        o_wen,
    output logic      [PORT_ADDR_W-1:0] o_waddr,
    output logic      [WORD_W-1:0]      o_wdata,
    output logic      [WORD_W-1:0]      o_wmask_n,
    // Read port
    output logic                        o_rclk,
    output logic                        o_rgate,
    output logic                        o_rstb,
    output logic      [PORT_ADDR_W-1:0] o_raddr
);
    logic [WORD_W-1:0] seen;
    event              done;
    initial {o_wclk, o_wgate, o_wen, o_rclk, o_rgate, o_rstb} = '0;
    initial {o_waddr, o_wdata, o_wmask_n, o_raddr} = '0;
    // Port clock high one cycle, then clock and enable low, address and data inverted
    task automatic put(input logic [10:0] a, input logic [15:0] d, input logic [15:0] m,
                       input logic g, input logic e);
        @(posedge i_clock);
        {o_wclk, o_wgate, o_wen, o_waddr, o_wdata, o_wmask_n} <= {1'b1, g, e, a, d, m};
        @(posedge i_clock);
        {o_wclk, o_wen, o_waddr, o_wdata} <= {2'b00, ~a, ~d};
    endtask : put
    // Reads run apart from writes, never one address on coinciding edges
    task automatic get(input logic [10:0] a, input logic g, input logic s);
        @(posedge i_clock);
        {o_rclk, o_rgate, o_rstb, o_raddr} <= {1'b1, g, s, a};
        @(posedge i_clock);
        {o_rclk, o_rstb, o_raddr} <= {2'b00, ~a};
        @(posedge i_clock);
        seen = i_rdata;
        -> done;
    endtask : get
endmodule : fabric_user

// [verif/dual_port_block_ram_4kbit_tb_top.sv]
// Self-checking bench for the dual-port block RAM
`timescale 1ns/1ps
module dual_port_block_ram_4kbit_tb_top
    import bram_pkg::*;
();
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        wclk, wgate, wen, rclk, rgate, rstb;
    logic [10:0] waddr, raddr;
    logic [15:0] wdat, wmask_n, rdat;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [33:0] expq[$];
    logic [15:0] lf = 16'hd606;
    logic [15:0] mv [8];
    logic [10:0] ad [8] = '{11'h0, 11'h1, 11'h24, 11'h55, 11'h80, 11'haa, 11'hfe, 11'hff};
    int          n_mismatch = 0;
    int          compares = 0;
    always #12.5 clock = ~clock;
    function automatic logic [15:0] pre(input int w);
        return 16'(w * 257) ^ 16'h5a00;
    endfunction : pre
    function automatic logic [INIT_STRINGS*INIT_W-1:0] img();
        for (int w = 0; w < DEPTH; w++) img[w*16 +: 16] = pre(w);
    endfunction : img
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    dual_port_block_ram_4kbit #(.PRELOAD_ENABLE(1'b1), .INIT_IMAGE(img())) i_dut (
        .I_CLOCK(clock), .I_RST(rst), .I_WRITE_CLK(wclk), .I_WRITE_PORT_CLOCK_GATE(wgate),
        .I_WRITE_ENABLE(wen), .I_WRITE_ADDR(waddr), .I_WRITE_DATA(wdat),
        .I_WRITE_MASK_N(wmask_n), .I_READ_CLK(rclk), .I_READ_PORT_CLOCK_GATE(rgate),
        .I_READ_STROBE(rstb), .I_READ_ADDR(raddr), .O_READ_DATA(rdat),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
        .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
        .I_RREADY(rready)
    );
    fabric_user i_user (
        .i_clock(clock), .i_rdata(rdat), .o_wclk(wclk), .o_wgate(wgate), .o_wen(wen),
        .o_waddr(waddr), .o_wdata(wdat), .o_wmask_n(wmask_n), .o_rclk(rclk),
        .o_rgate(rgate), .o_rstb(rstb), .o_raddr(raddr)
    );
    task automatic final_report();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [33:0] v);
        logic [33:0] e;
        compares++;
        e = (expq.size() > 0) ? expq.pop_front() : 'x;
        if (v !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, e, v);
        end
    endtask : check
    // Result watcher, oldest note first
    always @(i_user.done) check("read data", 34'(i_user.seen));
    always @(posedge clock) begin
        if (bvalid && bready) check("write response", 34'(bresp));
        if (rvalid && rready) check("register read", {rresp, rdata});
    end
    task automatic rd(input logic [10:0] a, input logic [15:0] e, input logic g, input logic s);
        expq.push_back(34'(e));
        i_user.get(a, g, s);
    endtask : rd
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w, b;
        expq.push_back(34'(r));
        {aw, w, b} = 3'b111;
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'b111};
        for (int k = 0; k < 50 && (aw || w || b); k++) begin
            @(posedge clock);
            if (awready) aw = 1'b0;
            if (wready) w = 1'b0;
            if (bvalid) b = 1'b0;
            {awvalid, wvalid, bready} <= {aw, w, b};
        end
        if (aw || w || b) begin
            n_mismatch++;
            final_report();
        end
    endtask : axw
    task automatic axr(input logic [3:0] a, input logic [33:0] e);
        logic ar, r;
        expq.push_back(e);
        {ar, r} = 2'b11;
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (int k = 0; k < 50 && (ar || r); k++) begin
            @(posedge clock);
            if (arready) ar = 1'b0;
            if (rvalid) r = 1'b0;
            {arvalid, rready} <= {ar, r};
        end
        if (ar || r) begin
            n_mismatch++;
            final_report();
        end
    endtask : axr
    initial begin
        {awaddr, araddr, wstrb, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        axr(STATUS_OFFSET, {RESP_OKAY, 32'h1});
        repeat (260) @(posedge clock);
        rd(ad[6], pre(ad[6]), 1'b1, 1'b1);
        rd(ad[7], pre(ad[7]), 1'b1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            mv[i] = lf;
            i_user.put(ad[i], lf, 16'h0, 1'b1, 1'b1);
        end
        for (int i = 0; i < 8; i++) rd(ad[i], mv[i], 1'b1, 1'b1);
        i_user.put(ad[2], 16'ha5a5, 16'h00ff, 1'b1, 1'b1);
        mv[2] = (mv[2] & 16'h00ff) | 16'ha500;
        i_user.put(ad[3], ~mv[3], 16'h0, 1'b1, 1'b0);
        i_user.put(ad[4], ~mv[4], 16'h0, 1'b0, 1'b1);
        for (int i = 2; i < 5; i++) rd(ad[i], mv[i], 1'b1, 1'b1);
        rd(ad[5], mv[4], 1'b1, 1'b0);
        rd(ad[5], mv[4], 1'b0, 1'b1);
        axw(CTRL_OFFSET, 32'h3, RESP_OKAY);
        axr(CTRL_OFFSET, {RESP_OKAY, 32'h3});
        i_user.put(ad[0], ~mv[0], 16'h0, 1'b1, 1'b1);
        rd(ad[1], mv[4], 1'b1, 1'b1);
        axw(CTRL_OFFSET, 32'h0, RESP_OKAY);
        rd(ad[0], mv[0], 1'b1, 1'b1);
        axr(STATUS_OFFSET, {RESP_OKAY, 16'h9, 16'h0});
        axw(RELOAD_OFFSET, 32'h1, RESP_OKAY);
        axr(STATUS_OFFSET, {RESP_OKAY, 16'h9, 16'h1});
        axr(RELOAD_OFFSET, {RESP_OKAY, 32'h0});
        repeat (260) @(posedge clock);
        rd(ad[2], pre(ad[2]), 1'b1, 1'b1);
        axw(4'hc, 32'hffffffff, RESP_SLVERR);
        axr(4'hc, {RESP_SLVERR, 32'h0});
        final_report();
    end
endmodule : dual_port_block_ram_4kbit_tb_top
